/* logic/cdx_pkg.sv */
package cdx_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000; // Core clock rate
  localparam int unsigned BYPASS_MS = 200; // Serial bypass wait, ms
  localparam int unsigned BYPASS_CYC = (CLK_HZ / 1000) * BYPASS_MS;
  localparam int unsigned ECHO_WAIT_US = 10; // Echo settle per pair, us
  localparam int unsigned ECHO_WAIT_CYC = (CLK_HZ / 1_000_000) * ECHO_WAIT_US;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SWRST = 8'h00; // Soft reset control
  localparam logic [7:0] IDX_PAIR = 8'h16; // diag_pair_select
  localparam logic [7:0] IDX_CTRL3 = 8'h1a; // extended_control_three
  localparam logic [7:0] IDX_STAT2 = 8'h1b; // extended_status_two
  localparam logic [7:0] IDX_DIAG = 8'h1c; // cable_diag_result
  localparam logic [7:0] IDX_IRQ_STAT = 8'h1d; // Sticky event status
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1e; // Event mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SWRST_BIT = 15;
  localparam int unsigned DIAG_EN_BIT = 15;
  localparam int unsigned BYP_EN_BIT = 12;
  localparam int unsigned BYP_ST_BIT = 11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] AMP_RST = 3'h2; // 0.60 V swing
  localparam logic [4:0] C3_NA_RST = 5'h01;
  localparam logic [2:0] S2_HI_RST = 3'h4;
  localparam logic S2_BYP_EN_RST = 1'b1;
  localparam logic [10:0] S2_NA_RST = 11'h008;

  // ----------------------------------------------------------------
  // Echo test result codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ECHO_NONE = 2'h0; // No fault found
  localparam logic [1:0] ECHO_SHORT = 2'h1;
  localparam logic [1:0] ECHO_OPEN = 2'h2;
  localparam logic [1:0] ECHO_FAIL = 2'h3;

  // ----------------------------------------------------------------
  // Interrupt event bits
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_ECHO_DONE = 0;
  localparam int unsigned IRQ_BYP_UP = 1;

  // State types
  typedef enum logic [2:0] {ECHO_IDLE, ECHO_LAUNCH, ECHO_WAIT, ECHO_STORE} cdx_echo_state_e;
  typedef enum logic [1:0] {SER_DOWN, SER_NEG, SER_UP} cdx_ser_state_e;

endpackage : cdx_pkg

/* logic/cdx_echo_engine.sv */
module cdx_echo_engine
  import cdx_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Control
  input wire logic soft_clr_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic link_up_i,
  input wire logic [1:0] sel_i,
  // Analog front end
  input wire logic [1:0] fe_fault_i,
  input wire logic [4:0] fe_mag_i,
  input wire logic [7:0] fe_dist_i,
  output logic [1:0] fe_pair_o,
  output logic fe_launch_o,
  // Results
  output logic busy_o,
  output logic done_o,
  output logic [1:0] rd_fault_o,
  output logic [4:0] rd_mag_o,
  output logic [7:0] rd_dist_o
);

  cdx_echo_state_e state_r; // Sequencer state
  logic [7:0] wait_r; // Settle counter
  logic [1:0] fault_r [4]; // Per-pair result code
  logic [4:0] mag_r [4]; // Per-pair echo magnitude
  logic [7:0] dist_r [4]; // Per-pair distance
  logic last_pair;
  logic [1:0] cap_fault;

  assign last_pair = (fe_pair_o == 2'h3);
  // Link rising mid-test spoils the measurement
  assign cap_fault = link_up_i ? ECHO_FAIL : fe_fault_i;
  // Result mux for the selected pair
  assign rd_fault_o = fault_r[sel_i];
  assign rd_mag_o = mag_r[sel_i];
  assign rd_dist_o = dist_r[sel_i];
  assign busy_o = (state_r != ECHO_IDLE);

  // Sequencer: launch, settle and capture pairs 0 to 3 in turn; copper link up ends the pass after the current pair
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ECHO_IDLE;
      wait_r <= 8'h00;
      fe_pair_o <= 2'h0;
      fe_launch_o <= 1'b0;
      done_o <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        fault_r[i] <= ECHO_NONE;
        mag_r[i] <= 5'h00;
        dist_r[i] <= 8'h00;
      end
    end else begin
      fe_launch_o <= 1'b0;
      done_o <= 1'b0;
      if (soft_clr_i || abort_i) begin
        state_r <= ECHO_IDLE;
        if (soft_clr_i) begin
          for (int i = 0; i < 4; i++) begin
            fault_r[i] <= ECHO_NONE;
            mag_r[i] <= 5'h00;
            dist_r[i] <= 8'h00;
          end
        end
      end else begin
        case (state_r)
          ECHO_IDLE: begin
            // Start only while copper link is down
            if (start_i && !link_up_i) begin
              fe_pair_o <= 2'h0;
              state_r <= ECHO_LAUNCH;
            end
          end
          ECHO_LAUNCH: begin
            fe_launch_o <= 1'b1;
            wait_r <= 8'(ECHO_WAIT_CYC - 1);
            state_r <= ECHO_WAIT;
          end
          ECHO_WAIT: begin
            if (wait_r == 8'h00) begin
              state_r <= ECHO_STORE;
            end else begin
              wait_r <= wait_r - 8'h01;
            end
          end
          ECHO_STORE: begin
            fault_r[fe_pair_o] <= cap_fault;
            mag_r[fe_pair_o] <= fe_mag_i;
            // Distance zero when nothing was found
            dist_r[fe_pair_o] <= (cap_fault == ECHO_NONE) ? 8'h00 : fe_dist_i;
            if (last_pair || link_up_i) begin
              done_o <= 1'b1;
              state_r <= ECHO_IDLE;
            end else begin
              fe_pair_o <= fe_pair_o + 2'h1;
              state_r <= ECHO_LAUNCH;
            end
          end
          default: state_r <= ECHO_IDLE;
        endcase
      end
    end
  end

endmodule : cdx_echo_engine

/* logic/cdx_an_bypass.sv */
module cdx_an_bypass
  import cdx_pkg::*;
#(
  parameter int unsigned TIMER_CYC = BYPASS_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Control
  input wire logic soft_clr_i,
  input wire logic bypass_en_i,
  input wire logic sig_ok_i,
  input wire logic an_done_i,
  // Status
  output logic link_up_o,
  output logic bypass_st_o,
  output logic up_evt_o
);

  localparam int unsigned CW = $clog2(TIMER_CYC + 1);

  cdx_ser_state_e state_r; // Serial link state
  logic [CW-1:0] cnt_r; // Negotiation timer
  logic expired;

  assign expired = (cnt_r == CW'(TIMER_CYC - 1));

  // Serial link bring-up with optional negotiation bypass
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= SER_DOWN;
      cnt_r <= '0;
      link_up_o <= 1'b0;
      bypass_st_o <= 1'b0;
      up_evt_o <= 1'b0;
    end else begin
      up_evt_o <= 1'b0;
      if (soft_clr_i) begin
        // Status is kept, link restarts
        state_r <= SER_DOWN;
        link_up_o <= 1'b0;
      end else begin
        case (state_r)
          SER_DOWN: begin
            cnt_r <= '0;
            if (sig_ok_i) begin
              state_r <= SER_NEG;
            end
          end
          SER_NEG: begin
            if (!sig_ok_i) begin
              state_r <= SER_DOWN;
            end else if (an_done_i) begin
              state_r <= SER_UP;
              link_up_o <= 1'b1;
              up_evt_o <= 1'b1;
              bypass_st_o <= 1'b0;
            end else if (bypass_en_i && expired) begin
              state_r <= SER_UP;
              link_up_o <= 1'b1;
              up_evt_o <= 1'b1;
              bypass_st_o <= 1'b1;
            end else if (!expired) begin
              cnt_r <= cnt_r + CW'(1);
            end
          end
          SER_UP: begin
            if (!sig_ok_i) begin
              state_r <= SER_DOWN;
              link_up_o <= 1'b0;
            end
          end
          default: state_r <= SER_DOWN;
        endcase
      end
    end
  end

endmodule : cdx_an_bypass

/* logic/cdx_cable_diag_regs.sv */
// Overview of operation
// - Enable bit starts test, link down only
// - Test runs despite partner negotiation pulses
// - Result code: fail, open, short, none
// - Five-bit echo magnitude, reset zero
// - Eight-bit distance field, scaled offset metres
// - No fault found gives zero distance
// - Amplitude field, 010 at reset, kept
// - Bypass enable brings link after 200 ms
// - Bypass status shows timer-driven link up
module cdx_cable_diag_regs
  import cdx_pkg::*;
#(
  parameter int unsigned BYPASS_TIMER_CYC = BYPASS_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic [9:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Copper side and echo front end
  input wire logic copper_link_up_i,
  input wire logic [1:0] fe_fault_i,
  input wire logic [4:0] fe_mag_i,
  input wire logic [7:0] fe_dist_i,
  output logic [1:0] fe_pair_o,
  output logic fe_launch_o,
  // Serial side
  input wire logic serdes_sig_ok_i,
  input wire logic serdes_an_done_i,
  output logic serial_link_up_o,
  output logic [2:0] rx_amp_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 18;

  logic [SYNC_W-1:0] sync_a_r; // First stage, read only by second
  logic [SYNC_W-1:0] sync_b_r; // Second stage, safe to use
  logic link_s;
  logic [1:0] fault_s;
  logic [4:0] mag_s;
  logic [7:0] dist_s;
  logic sig_ok_s;
  logic an_done_s;

  // Two flops on every pin; front-end data is sampled only after settle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_a_r <= '0;
      sync_b_r <= '0;
    end else begin
      sync_a_r <= {copper_link_up_i, fe_fault_i, fe_mag_i, fe_dist_i,
                   serdes_sig_ok_i, serdes_an_done_i};
      sync_b_r <= sync_a_r;
    end
  end

  assign {link_s, fault_s, mag_s, dist_s, sig_ok_s, an_done_s} = sync_b_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] idx; // Word index
  logic aligned; // Low address bits zero
  logic setup_ph; // First cycle of a transfer
  logic wr_acc; // Write takes effect now
  logic rd_acc; // Read completes now
  logic hit_swrst;
  logic hit_pair;
  logic hit_ctrl3;
  logic hit_stat2;
  logic hit_diag;
  logic hit_istat;
  logic hit_imask;
  logic hit_any;

  assign idx = paddr_i[9:2];
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign setup_ph = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_acc = psel_i && penable_i && !pwrite_i && pready_o;
  assign hit_swrst = aligned && (idx == IDX_SWRST);
  assign hit_pair = aligned && (idx == IDX_PAIR);
  assign hit_ctrl3 = aligned && (idx == IDX_CTRL3);
  assign hit_stat2 = aligned && (idx == IDX_STAT2);
  assign hit_diag = aligned && (idx == IDX_DIAG);
  assign hit_istat = aligned && (idx == IDX_IRQ_STAT);
  assign hit_imask = aligned && (idx == IDX_IRQ_MASK);
  assign hit_any = hit_swrst || hit_pair || hit_ctrl3 || hit_stat2 ||
                   hit_diag || hit_istat || hit_imask;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [1:0] pair_sel_r; // Selected twisted pair
  logic [4:0] c3_na_r; // Preserved field, written copy
  logic [4:0] c3_na_act_r; // Preserved field, applied copy
  logic [2:0] amp_r; // Receive output swing
  logic byp_en_r; // Bypass enable, written copy
  logic byp_en_act_r; // Bypass enable, applied copy
  logic [10:0] s2_na_r; // Preserved field, written copy
  logic [10:0] s2_na_act_r; // Preserved field, applied copy
  logic diag_en_r; // Echo test enable
  logic start_pend_r; // Start waiting for link down
  logic soft_rst_r; // One-cycle software reset pulse
  logic [IRQ_W-1:0] irq_stat_r; // Sticky events
  logic [IRQ_W-1:0] irq_mask_r; // Event enables

  // Engine and bypass status
  logic eng_busy;
  logic eng_done;
  logic [1:0] rd_fault;
  logic [4:0] rd_mag;
  logic [7:0] rd_dist;
  logic byp_st;
  logic ser_up_evt;
  logic eng_start;
  logic eng_abort;
  logic [IRQ_W-1:0] irq_evt;

  // Software reset strobe from bit 15 of the control word
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_acc && hit_swrst && pwdata_i[SWRST_BIT];
    end
  end

  // Pair select; upper bits are not stored at all
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pair_sel_r <= 2'h0;
    end else if (wr_acc && hit_pair) begin
      pair_sel_r <= pwdata_i[1:0];
    end
  end

  // Control three: amplitude applies at once and survives soft reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      amp_r <= AMP_RST;
      c3_na_r <= C3_NA_RST;
      c3_na_act_r <= C3_NA_RST;
    end else begin
      if (wr_acc && hit_ctrl3) begin
        amp_r <= pwdata_i[2:0];
        c3_na_r <= pwdata_i[7:3];
      end
      if (soft_rst_r) begin
        c3_na_act_r <= c3_na_r;
      end
    end
  end

  // Status two: written values take effect only on software reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byp_en_r <= S2_BYP_EN_RST;
      byp_en_act_r <= S2_BYP_EN_RST;
      s2_na_r <= S2_NA_RST;
      s2_na_act_r <= S2_NA_RST;
    end else begin
      if (wr_acc && hit_stat2) begin
        byp_en_r <= pwdata_i[BYP_EN_BIT];
        s2_na_r <= pwdata_i[10:0];
      end
      if (soft_rst_r) begin
        byp_en_act_r <= byp_en_r;
        s2_na_act_r <= s2_na_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Echo test control
  // ----------------------------------------------------------------
  // A write of one starts a pass; a pass waits while the copper link is up
  // and never looks at what the partner sends, so negotiation pulses or
  // idle link pulses do not hold it off.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_en_r <= 1'b0;
      start_pend_r <= 1'b0;
    end else if (soft_rst_r) begin
      diag_en_r <= 1'b0;
      start_pend_r <= 1'b0;
    end else if (wr_acc && hit_diag) begin
      diag_en_r <= pwdata_i[DIAG_EN_BIT];
      start_pend_r <= pwdata_i[DIAG_EN_BIT];
    end else if (eng_start) begin
      start_pend_r <= 1'b0;
    end
  end

  assign eng_start = start_pend_r && diag_en_r && !eng_busy && !link_s;
  assign eng_abort = !diag_en_r && eng_busy;

  cdx_echo_engine u_echo (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .soft_clr_i(soft_rst_r),
    .start_i(eng_start),
    .abort_i(eng_abort),
    .link_up_i(link_s),
    .sel_i(pair_sel_r),
    .fe_fault_i(fault_s),
    .fe_mag_i(mag_s),
    .fe_dist_i(dist_s),
    .fe_pair_o(fe_pair_o),
    .fe_launch_o(fe_launch_o),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .rd_fault_o(rd_fault),
    .rd_mag_o(rd_mag),
    .rd_dist_o(rd_dist)
  );

  // ----------------------------------------------------------------
  // Serial side bring-up
  // ----------------------------------------------------------------
  cdx_an_bypass #(
    .TIMER_CYC(BYPASS_TIMER_CYC)
  ) u_bypass (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .soft_clr_i(soft_rst_r),
    .bypass_en_i(byp_en_act_r),
    .sig_ok_i(sig_ok_s),
    .an_done_i(an_done_s),
    .link_up_o(serial_link_up_o),
    .bypass_st_o(byp_st),
    .up_evt_o(ser_up_evt)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_evt = {ser_up_evt, eng_done};

  // Sticky status, cleared by reading it; a new event in the same cycle wins
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_o <= 1'b0;
    end else begin
      if (rd_acc && hit_istat) begin
        irq_stat_r <= irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_acc && hit_imask) begin
        irq_mask_r <= pwdata_i[IRQ_W-1:0];
      end
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] rd_pair;
  logic [15:0] rd_ctrl3;
  logic [15:0] rd_stat2;
  logic [15:0] rd_diag;
  logic [15:0] rd_word;

  // Reserved bits read as zero
  assign rd_pair = {14'h0000, pair_sel_r};
  assign rd_ctrl3 = {8'h00, c3_na_r, amp_r};
  assign rd_stat2 = {S2_HI_RST, byp_en_r, byp_st, s2_na_r};
  assign rd_diag = {diag_en_r, rd_fault, rd_mag, rd_dist};
  assign rd_word = hit_pair ? rd_pair :
                   hit_ctrl3 ? rd_ctrl3 :
                   hit_stat2 ? rd_stat2 :
                   hit_diag ? rd_diag :
                   hit_istat ? {14'h0000, irq_stat_r} :
                   hit_imask ? {14'h0000, irq_mask_r} :
                   16'h0000;

  // Zero-wait slave: data and error latched in the setup cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      if (setup_ph) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : {16'h0000, rd_word};
        pslverr_o <= !hit_any;
      end
    end
  end

  // Amplitude code straight from its register
  assign rx_amp_o = amp_r;

endmodule : cdx_cable_diag_regs

/* tb/cdx_regs_asserts.sv */
module cdx_regs_asserts
  import cdx_pkg::*;
#(
  parameter int unsigned TIMER_CYC = BYPASS_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Bus
  input wire logic [9:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Line sides
  input wire logic copper_link_up_i,
  input wire logic [1:0] fe_pair_o,
  input wire logic fe_launch_o,
  input wire logic serdes_sig_ok_i,
  input wire logic serdes_an_done_i,
  input wire logic serial_link_up_o,
  input wire logic [2:0] rx_amp_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Copper up run length, saturating
  logic [3:0] up_cnt_r;
  // Serial signal run length; 32 bits outlasts any timer
  logic [31:0] sig_cnt_r;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_cnt_r <= 4'h0;
      sig_cnt_r <= 32'h0;
    end else begin
      up_cnt_r <= !copper_link_up_i ? 4'h0 : (&up_cnt_r ? up_cnt_r : up_cnt_r + 4'h1);
      sig_cnt_r <= serdes_sig_ok_i ? sig_cnt_r + 32'h1 : 32'h0;
    end
  end
  a_upper_zero: assert property (prdata_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_zero_wait: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
  a_launch_pulse: assert property (fe_launch_o |=> !fe_launch_o)
    else $error("launch longer than one cycle");
  a_no_launch_up: assert property (up_cnt_r > 4'h5 |-> !fe_launch_o)
    else $error("echo launched with link up");
  a_amp_reset: assert property (!$past(arst_n_i) |-> rx_amp_o == AMP_RST)
    else $error("amplitude not at reset value");
  a_serial_cause: assert property ($rose(serial_link_up_o) |-> $past(serdes_sig_ok_i))
    else $error("serial link up without signal");
  a_bypass_time: assert property ($rose(serial_link_up_o) && !serdes_an_done_i
    |-> sig_cnt_r >= TIMER_CYC)
    else $error("bypass link up too early");
  a_pair_stable: assert property (fe_launch_o |=> $stable(fe_pair_o) [*4])
    else $error("pair moved during echo");
  a_unaligned_err: assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0
    |=> pslverr_o)
    else $error("unaligned access not refused");
  a_err_reads_zero: assert property (pslverr_o && psel_i && penable_i
    |-> prdata_o == 32'h0)
    else $error("refused read not zero");
  c_launch: cover property (fe_launch_o);
  c_serial_up: cover property ($rose(serial_link_up_o));
  c_irq: cover property ($rose(irq_o));
endmodule : cdx_regs_asserts

bind cdx_cable_diag_regs cdx_regs_asserts #(.TIMER_CYC(BYPASS_TIMER_CYC)) i_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .copper_link_up_i(copper_link_up_i), .fe_pair_o(fe_pair_o), .fe_launch_o(fe_launch_o),
  .serdes_sig_ok_i(serdes_sig_ok_i), .serdes_an_done_i(serdes_an_done_i),
  .serial_link_up_o(serial_link_up_o), .rx_amp_o(rx_amp_o), .irq_o(irq_o));

/* tb/cdx_fe_model.sv */
module cdx_fe_model (
  // Clock
  input wire logic clock_i,
  // Engine request
  input wire logic [1:0] pair_i,
  input wire logic launch_i,
  // Per pair answers, pair 0 lowest
  input wire logic [7:0] flt_tbl_i,
  input wire logic [19:0] mag_tbl_i,
  input wire logic [31:0] dist_tbl_i,
  // Echo results
  output logic [1:0] fault_o,
  output logic [4:0] mag_o,
  output logic [7:0] dist_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Garbage until the first echo, so nothing passes by luck
  initial {fault_o, mag_o, dist_o} = 15'h5aa5;
  // Echo answer appears only after a launch on that pair
  always @(posedge clock_i) begin
    if (launch_i) begin
      fault_o <= flt_tbl_i[2*pair_i +: 2];
      mag_o <= mag_tbl_i[5*pair_i +: 5];
      dist_o <= dist_tbl_i[8*pair_i +: 8];
    end
  end
endmodule : cdx_fe_model

/* tb/cable_diag_and_ext_ctrl_regs_test.sv */
module cable_diag_and_ext_ctrl_regs_test
  import cdx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus and observed signals
  logic clock_i = 0, arst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, cu = 0, sig_ok = 0, an_done = 0, launch, ser_up, irq;
  logic [1:0] fflt, fpair;
  logic [4:0] fmag;
  logic [7:0] fdist, flt_tbl = 0;
  logic [19:0] mag_tbl = 0;
  logic [31:0] dist_tbl = 0;
  logic [2:0] amp, rx_amp;
  int n_errors = 0, cmp_count = 0, n_launch = 0, cyc = 0, n;
  // ----------------------------------------------------------------
  // Design and far-side model
  // ----------------------------------------------------------------
  // Short bypass timer keeps the serial scenarios brief
  cdx_cable_diag_regs #(.BYPASS_TIMER_CYC(50)) i_dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .copper_link_up_i(cu), .fe_fault_i(fflt),
    .fe_mag_i(fmag), .fe_dist_i(fdist), .fe_pair_o(fpair), .fe_launch_o(launch),
    .serdes_sig_ok_i(sig_ok), .serdes_an_done_i(an_done), .serial_link_up_o(ser_up),
    .rx_amp_o(rx_amp), .irq_o(irq));
  cdx_fe_model i_fe (
    .clock_i(clock_i), .pair_i(fpair), .launch_i(launch), .flt_tbl_i(flt_tbl),
    .mag_tbl_i(mag_tbl), .dist_tbl_i(dist_tbl), .fault_o(fflt), .mag_o(fmag),
    .dist_o(fdist));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #25 clock_i = ~clock_i;
  end

  // Expected result word for one pair, from the model's tables
  function automatic logic [31:0] diag_exp(input logic [1:0] p);
    logic [1:0] f;
    f = flt_tbl[2*p +: 2];
    return {16'h0000, 1'b1, f, mag_tbl[5*p +: 5], (f == ECHO_NONE) ? 8'h00 : dist_tbl[8*p +: 8]};
  endfunction : diag_exp

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; starts just after an edge, ends just after one
  task automatic apb(input logic w, input logic [9:0] a, input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (!pready) @(posedge clock_i);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // A hang counts as a mismatch
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(66231));
    flt_tbl <= {$urandom} & 8'hfc; // Pair A finds nothing: zero distance corner
    mag_tbl <= $urandom;
    dist_tbl <= $urandom;
    amp <= $urandom;
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    chk("amp at reset", {29'h0, rx_amp}, 32'h2);
    apb(1'b0, {IDX_CTRL3, 2'b00}, 16'h0000);
    chk("ctrl3 reset", q, 32'h000a);
    apb(1'b0, {IDX_STAT2, 2'b00}, 16'h0000);
    chk("stat2 reset", q, 32'h9008);
    // Amplitude write keeps the preserved field as read
    apb(1'b1, {IDX_CTRL3, 2'b00}, {8'h00, 5'h01, amp});
    chk("amp pin", {29'h0, rx_amp}, {29'h0, amp});
    apb(1'b0, {IDX_CTRL3, 2'b00}, 16'h0000);
    chk("ctrl3 back", q, {24'h0, 5'h01, amp});
    apb(1'b1, {IDX_PAIR, 2'b00}, 16'hffff);
    apb(1'b0, {IDX_PAIR, 2'b00}, 16'h0000);
    chk("pair reserved", q, 32'h3);
    apb(1'b0, {IDX_PAIR, 2'b01}, 16'h0000);
    chk("unaligned err", {31'h0, e}, 32'h1);
    // Echo test with copper link down
    apb(1'b1, {IDX_IRQ_MASK, 2'b00}, 16'h0003);
    apb(1'b1, {IDX_DIAG, 2'b00}, 16'h8000);
    while (!irq) @(posedge clock_i);
    for (n = 0; n < 4; n++) begin
      apb(1'b1, {IDX_PAIR, 2'b00}, 16'(n));
      apb(1'b0, {IDX_DIAG, 2'b00}, 16'h0000);
      chk("diag pair", q, diag_exp(2'(n)));
    end
    apb(1'b0, {IDX_IRQ_STAT, 2'b00}, 16'h0000);
    chk("irq done", q, 32'h1);
    apb(1'b0, {IDX_IRQ_STAT, 2'b00}, 16'h0000);
    chk("irq cleared", q, 32'h0);
    chk("irq pin low", {31'h0, irq}, 32'h0);
    // Serial link up by bypass timer
    sig_ok <= 1'b1;
    while (!ser_up) @(posedge clock_i);
    apb(1'b0, {IDX_STAT2, 2'b00}, 16'h0000);
    chk("bypass status", q, 32'h9808);
    apb(1'b0, {IDX_IRQ_STAT, 2'b00}, 16'h0000);
    chk("irq serial", q, 32'h2);
    // Software reset, then regular negotiation
    an_done <= 1'b1;
    apb(1'b1, {IDX_SWRST, 2'b00}, 16'h8000);
    repeat (3) @(posedge clock_i);
    while (!ser_up) @(posedge clock_i);
    apb(1'b0, {IDX_STAT2, 2'b00}, 16'h0000);
    chk("negotiated status", q, 32'h9008);
    chk("amp kept", {29'h0, rx_amp}, {29'h0, amp});
    apb(1'b0, {IDX_DIAG, 2'b00}, 16'h0000);
    chk("diag soft reset", q, 32'h0);
    test_done();
  end
endmodule : cable_diag_and_ext_ctrl_regs_test
